/* inc/hbc_pkg.sv */
package hbc_pkg;
    // Register offsets
    localparam logic [7:0] HBC_OFS_CMD = 8'h08;
    localparam logic [7:0] HBC_OFS_PIN = 8'h09;
    localparam logic [7:0] HBC_OFS_PROT = 8'h0a;
    localparam logic [7:0] HBC_OFS_DRV = 8'h0b;
    localparam logic [7:0] HBC_OFS_TMD = 8'h0c;
    localparam logic [7:0] HBC_OFS_COMB = 8'h0d;
    // Reset values
    localparam logic [7:0] HBC_RST_CMD = 8'h09;
    localparam logic [7:0] HBC_RST_PIN = 8'h0c;
    localparam logic [7:0] HBC_RST_PROT = 8'h10;
    localparam logic [7:0] HBC_RST_DRV = 8'h00;
    localparam logic [7:0] HBC_RST_TMD = 8'h40;
    localparam logic [7:0] HBC_RST_COMB = 8'h04;
    // Writable bit masks; other bits, bar the command clear bit, are reserved and read zero
    localparam logic [7:0] HBC_MSK_CMD = 8'h1b;
    localparam logic [7:0] HBC_MSK_PIN = 8'h0f;
    localparam logic [7:0] HBC_MSK_PROT = 8'hff;
    localparam logic [7:0] HBC_MSK_DRV = 8'he7;
    localparam logic [7:0] HBC_MSK_TMD = 8'hdf;
    localparam logic [7:0] HBC_MSK_COMB = 8'h07;
    // Field positions
    localparam int HBC_POS_CLR = 7;
    localparam int HBC_POS_INLK = 3;
    localparam int HBC_POS_CFLK = 0;
    localparam logic [1:0] HBC_LOCK_KEY = 2'b10;
    localparam int HBC_POS_SOFF1 = 3;
    localparam int HBC_POS_SOFF2 = 2;
    localparam int HBC_POS_EN1 = 1;
    localparam int HBC_POS_PH2 = 0;
    localparam int HBC_POS_OLEN = 7;
    localparam int HBC_POS_OVSEL = 5;
    localparam int HBC_POS_SSDIS = 4;
    localparam int HBC_POS_OCRT = 3;
    localparam int HBC_POS_OTRT = 2;
    localparam int HBC_POS_OVRT = 1;
    localparam int HBC_POS_OLRT = 0;
    localparam int HBC_POS_PWMX = 7;
    localparam int HBC_POS_LOAD = 5;
    localparam int HBC_POS_TRIP = 0;
    localparam int HBC_POS_REGULATION_OFF_TIME = 6;
    localparam int HBC_POS_SLEW = 2;
    localparam int HBC_POS_MODE = 0;
    // Bridge modes and load types
    localparam logic [1:0] HBC_MODE_INDEP = 2'b10;
    localparam logic [1:0] HBC_LOAD_LOWSIDE = 2'b01;
    // Regulation off time in microseconds per code, and clock rate
    localparam int HBC_REGULATION_OFF_TIME_BASE_US = 20;
    localparam int HBC_REGULATION_OFF_TIME_STEP_US = 10;
    localparam int HBC_CLK_MHZ = 100;
    localparam int HBC_REGULATION_OFF_TIME_BASE_CYC = HBC_REGULATION_OFF_TIME_BASE_US * HBC_CLK_MHZ;
    localparam int HBC_REGULATION_OFF_TIME_STEP_CYC = HBC_REGULATION_OFF_TIME_STEP_US * HBC_CLK_MHZ;
endpackage : hbc_pkg

/* logic/hbc_regs.sv */
`timescale 1ns/1ps
// Functional notes
// RQ1: Fault clear write clears faults, releases indicator
// RQ2: Override lock opens only on code 10b
// RQ3: Config lock closes only on code 10b
// RQ4: Register shutoff 1 mirrors pin; bridge1 independently
// RQ5: Register shutoff 2 stops bridge 2, resets one
// RQ6: Register enable/input1 mirrors pin, resets zero
// RQ7: Register phase/input2 mirrors pin, resets zero
// RQ8: Pin and register combined by OR/AND select
// RQ9: Open-load enable bit enables active detection
// RQ10: Independent low-side load disables active open-load
// RQ11: Overvoltage select: 35, 28, 18 V, off
// RQ12: Spread-spectrum disable bit, resets to one
// RQ13: Overcurrent retry versus latched reaction
// RQ14: Overtemperature retry versus latched reaction
// RQ15: Overvoltage retry versus latched reaction
// RQ16: Overvoltage retry also governs undervoltage reaction
// RQ17: Open-load retry versus latched reaction
// RQ18: PWM extension enables extra coast states
// RQ19: Load type field in bits 6:5
// RQ20: Current trip level in bits 2:0
// RQ21: Off time 20/30/40/50 us by code
// RQ22: Slew rate field in bits 4:2
// RQ23: Bridge mode field in bits 1:0
// RQ24: Locked writes ignored; reserved bits read zero
// RQ25: Fault clear bit self-clears
module hbc_regs import hbc_pkg::*; (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_n, // Sync reset, low
    input wire logic wr_en, // Register write strobe
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    output logic [7:0] rdata, // Read data, registered
    input wire logic shutoff_pin, // Shutoff pin, async
    input wire logic enable_input1_pin, // Enable/IN1 pin, async
    input wire logic phase_input2_pin, // Phase/IN2 pin, async
    input wire logic fault_detected, // Any fault pending in fault registers
    output logic fault_clear_pulse, // One-cycle fault clear
    output logic fault_indicator_pin_n, // Fault indicator, low active
    output logic shutoff_1, // Effective shutoff, half-bridge 1
    output logic shutoff_2, // Effective shutoff, half-bridge 2
    output logic enable_input1, // Effective enable/IN1
    output logic phase_input2, // Effective phase/IN2
    output logic openload_active_en, // Active open-load detection on
    output logic [1:0] overvoltage_threshold_sel, // 00 35V,01 28V,10 18V,11 off
    output logic overvoltage_check_en, // Overvoltage check enabled
    output logic spread_clock_en, // Spread-spectrum clocking on
    output logic overcurrent_retry, // 1 retry, 0 latched
    output logic overtemp_retry, // 1 retry, 0 latched
    output logic overvoltage_retry, // 1 retry, 0 latched
    output logic undervoltage_retry, // Same as overvoltage retry
    output logic openload_retry, // 1 retry, 0 latched
    output logic pwm_extend, // Extra coast states in PWM
    output logic [1:0] load_type_sel, // Load type
    output logic [2:0] current_trip_level, // Trip level
    output logic [1:0] regulation_off_time, // Off time code
    output logic [15:0] off_time_cycles, // Off time in clock cycles
    output logic [2:0] slew_rate_sel, // Slew rate
    output logic [1:0] bridge_mode // Bridge control mode
);
    logic [7:0] cmd_q; // command_control
    logic [7:0] pin_q; // pin_override_inputs
    logic [7:0] prot_q; // protection_config
    logic [7:0] drv_q; // drive_regulation_config
    logic [7:0] tmd_q; // timing_mode_config
    logic [7:0] comb_q; // Combine selects
    logic [2:0] pins_s; // Synchronised pins
    logic in_unlocked; // Override register writable
    logic cfg_locked; // Config registers frozen
    logic fault_ind_q; // Fault indicator, high while asserted
    logic wr_cmd; // Write hits command_control
    logic wr_pin; // Write hits pin_override_inputs
    logic wr_prot; // Write hits protection_config
    logic wr_drv; // Write hits drive_regulation_config
    logic wr_tmd; // Write hits timing_mode_config
    logic wr_comb; // Write hits combine selects
    logic indep_mode; // Bridge runs as two half-bridges
    logic lowside_load; // Load declared as low-side

    // Masked update helper
    function automatic logic [7:0] hbc_upd(input logic [7:0] mask, input logic [7:0] d);
        hbc_upd = d & mask;
    endfunction : hbc_upd

    // Pin combine helper: select 0 OR, 1 AND
    function automatic logic hbc_comb(input logic sel, input logic p, input logic r);
        hbc_comb = sel ? (p & r) : (p | r);
    endfunction : hbc_comb

    // Write address match, shared by every register
    function automatic logic hbc_hit(input logic we, input logic [7:0] a, input logic [7:0] ofs);
        hbc_hit = we && (a == ofs);
    endfunction : hbc_hit

    hbc_sync #(.W(3)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({shutoff_pin, enable_input1_pin, phase_input2_pin}),
        .sync_out(pins_s)
    );

    // Lock decode
    assign in_unlocked = (cmd_q[HBC_POS_INLK +: 2] == HBC_LOCK_KEY); // [RQ2]
    assign cfg_locked = (cmd_q[HBC_POS_CFLK +: 2] == HBC_LOCK_KEY); // [RQ3]

    // Write selects, one per register
    assign wr_cmd = hbc_hit(wr_en, addr, HBC_OFS_CMD);
    assign wr_pin = hbc_hit(wr_en, addr, HBC_OFS_PIN);
    assign wr_prot = hbc_hit(wr_en, addr, HBC_OFS_PROT);
    assign wr_drv = hbc_hit(wr_en, addr, HBC_OFS_DRV);
    assign wr_tmd = hbc_hit(wr_en, addr, HBC_OFS_TMD);
    assign wr_comb = hbc_hit(wr_en, addr, HBC_OFS_COMB);

    // Mode decode used by shutoff_2 and openload_active_en, load decode by openload_active_en only
    assign indep_mode = (bridge_mode == HBC_MODE_INDEP);
    assign lowside_load = (load_type_sel == HBC_LOAD_LOWSIDE);

    // Command register; clear bit self-clears next cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmd_q <= HBC_RST_CMD;
        end else if (wr_cmd) begin // Always writable, even when locked
            cmd_q <= hbc_upd(HBC_MSK_CMD, wdata) | {wdata[HBC_POS_CLR], 7'h00}; // [RQ24]
        end else begin
            cmd_q[HBC_POS_CLR] <= 1'b0; // [RQ25]
        end
    end

    assign fault_clear_pulse = cmd_q[HBC_POS_CLR]; // [RQ1]

    // Fault indicator: set by faults, released by clear; set wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_ind_q <= 1'b0;
        end else if (fault_detected) begin
            fault_ind_q <= 1'b1;
        end else if (fault_clear_pulse) begin
            fault_ind_q <= 1'b0; // [RQ1]
        end
    end

    assign fault_indicator_pin_n = ~fault_ind_q;

    // Override register, writable only while unlocked
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_q <= HBC_RST_PIN; // [RQ5] [RQ6] [RQ7]
        end else if (wr_pin && in_unlocked) begin
            pin_q <= hbc_upd(HBC_MSK_PIN, wdata); // [RQ24]
        end
    end

    // Protection register, frozen while config is locked
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prot_q <= HBC_RST_PROT; // [RQ12]
        end else if (wr_prot && !cfg_locked) begin // [RQ24]
            prot_q <= hbc_upd(HBC_MSK_PROT, wdata);
        end
    end

    // Drive register, frozen while config is locked
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            drv_q <= HBC_RST_DRV;
        end else if (wr_drv && !cfg_locked) begin // [RQ24]
            drv_q <= hbc_upd(HBC_MSK_DRV, wdata);
        end
    end

    // Timing and mode register, frozen while config is locked
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tmd_q <= HBC_RST_TMD;
        end else if (wr_tmd && !cfg_locked) begin // [RQ24]
            tmd_q <= hbc_upd(HBC_MSK_TMD, wdata);
        end
    end

    // Combine selects, frozen while config is locked
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            comb_q <= HBC_RST_COMB;
        end else if (wr_comb && !cfg_locked) begin // [RQ24]
            comb_q <= hbc_upd(HBC_MSK_COMB, wdata);
        end
    end

    // Read data register, one edge after the address; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            case (addr)
                HBC_OFS_CMD: rdata <= cmd_q;
                HBC_OFS_PIN: rdata <= pin_q;
                HBC_OFS_PROT: rdata <= prot_q;
                HBC_OFS_DRV: rdata <= drv_q;
                HBC_OFS_TMD: rdata <= tmd_q;
                HBC_OFS_COMB: rdata <= comb_q;
                default: rdata <= 8'h00; // Reserved space reads zero
            endcase
        end
    end

    // Effective inputs: pins alone when locked, combined when unlocked
    always_comb begin
        if (in_unlocked) begin
            shutoff_1 = hbc_comb(comb_q[2], pins_s[2], pin_q[HBC_POS_SOFF1]); // [RQ4] [RQ8]
            enable_input1 = hbc_comb(comb_q[1], pins_s[1], pin_q[HBC_POS_EN1]); // [RQ6] [RQ8]
            phase_input2 = hbc_comb(comb_q[0], pins_s[0], pin_q[HBC_POS_PH2]); // [RQ7] [RQ8]
            // Second shutoff acts only in independent mode
            shutoff_2 = indep_mode ?
                hbc_comb(comb_q[2], pins_s[2], pin_q[HBC_POS_SOFF2]) : shutoff_1; // [RQ5]
        end else begin
            shutoff_1 = pins_s[2];
            enable_input1 = pins_s[1];
            phase_input2 = pins_s[0];
            shutoff_2 = pins_s[2];
        end
    end

    // Protection fields
    assign openload_active_en = prot_q[HBC_POS_OLEN] // [RQ9]
        & ~(indep_mode & lowside_load); // [RQ10]
    assign overvoltage_threshold_sel = prot_q[HBC_POS_OVSEL +: 2]; // [RQ11]
    assign overvoltage_check_en = (prot_q[HBC_POS_OVSEL +: 2] != 2'b11); // [RQ11]
    assign spread_clock_en = ~prot_q[HBC_POS_SSDIS]; // [RQ12]
    assign overcurrent_retry = prot_q[HBC_POS_OCRT]; // [RQ13]
    assign overtemp_retry = prot_q[HBC_POS_OTRT]; // [RQ14]
    assign overvoltage_retry = prot_q[HBC_POS_OVRT]; // [RQ15]
    assign undervoltage_retry = prot_q[HBC_POS_OVRT]; // [RQ16]
    assign openload_retry = prot_q[HBC_POS_OLRT]; // [RQ17]

    // Drive fields
    assign pwm_extend = drv_q[HBC_POS_PWMX]; // [RQ18]
    assign load_type_sel = drv_q[HBC_POS_LOAD +: 2]; // [RQ19]
    assign current_trip_level = drv_q[HBC_POS_TRIP +: 3]; // [RQ20]
    assign regulation_off_time = tmd_q[HBC_POS_REGULATION_OFF_TIME +: 2];
    assign off_time_cycles = 16'(HBC_REGULATION_OFF_TIME_BASE_CYC
        + HBC_REGULATION_OFF_TIME_STEP_CYC * int'(regulation_off_time)); // [RQ21]
    assign slew_rate_sel = tmd_q[HBC_POS_SLEW +: 3]; // [RQ22]
    assign bridge_mode = tmd_q[HBC_POS_MODE +: 2]; // [RQ23]
endmodule : hbc_regs

/* logic/hbc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels
module hbc_sync import hbc_pkg::*; #(
    parameter int W = 3
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Sync reset, low
    input wire logic [W-1:0] async_in, // Raw pins
    output logic [W-1:0] sync_out // Synchronised pins
);
    logic [W-1:0] meta_q; // First stage, read only by second

    // Two flops in series
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : hbc_sync

/* testbench/hbc_host.sv */
`timescale 1ns/1ps
// Host model: single-byte register writes and reads
module hbc_host (
    input wire logic ref_clk, // Clock
    input wire logic [7:0] rdata, // Read data
    output logic wr_en, // Write strobe
    output logic [7:0] addr, // Address
    output logic [7:0] wdata // Data
);
    // Idle bus at time zero
    initial begin
        wr_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // Write taken at the edge where the strobe is high
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    // Read data is registered: taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        @(posedge ref_clk);
        #1 d = rdata;
    endtask : rd
endmodule : hbc_host

/* testbench/hbc_regs_chk.sv */
`timescale 1ns/1ps
// Port-level checks on the register block
module hbc_regs_chk import hbc_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic wr_en, // Write strobe
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wdata, // Data
    input wire logic enable_input1_pin, // Raw pin
    input wire logic enable_input1, // Effective
    input wire logic fault_detected, // Fault pending
    input wire logic fault_clear_pulse, // Clear pulse
    input wire logic fault_indicator_pin_n, // Indicator
    input wire logic openload_active_en, // Open-load on
    input wire logic [1:0] overvoltage_threshold_sel, // Threshold
    input wire logic overvoltage_check_en, // Check on
    input wire logic overcurrent_retry, // Retry
    input wire logic overvoltage_retry, // Retry
    input wire logic undervoltage_retry, // Retry
    input wire logic [1:0] load_type_sel, // Load
    input wire logic [1:0] regulation_off_time, // Off code
    input wire logic [15:0] off_time_cycles, // Off cycles
    input wire logic [1:0] bridge_mode // Mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic unl_q; // Override unlocked
    logic cfl_q; // Config locked
    // Lock state seen from command writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            unl_q <= 1'b0;
            cfl_q <= 1'b0;
        end else if (wr_en && addr == HBC_OFS_CMD) begin
            unl_q <= wdata[4:3] == HBC_LOCK_KEY;
            cfl_q <= wdata[1:0] == HBC_LOCK_KEY;
        end
    end
    sequence clr_wr;
        wr_en && addr == HBC_OFS_CMD && wdata[HBC_POS_CLR];
    endsequence
    sequence cfg_wr;
        wr_en && addr == HBC_OFS_PROT && cfl_q;
    endsequence
    clr_pulse_a: assert property (clr_wr |=> fault_clear_pulse)
        else $error("clear pulse missing");
    pulse_once_a: assert property (fault_clear_pulse |=> !fault_clear_pulse)
        else $error("clear pulse too long");
    pulse_cause_a: assert property ($rose(fault_clear_pulse) |-> $past(wr_en))
        else $error("clear pulse without write");
    ind_release_a: assert property (fault_clear_pulse && !fault_detected |=>
        fault_indicator_pin_n) else $error("indicator not released");
    ov_off_a: assert property (overvoltage_check_en ==
        (overvoltage_threshold_sel != 2'b11)) else $error("overvoltage check decode");
    uv_copy_a: assert property (undervoltage_retry == overvoltage_retry)
        else $error("undervoltage retry differs");
    regulation_off_time_cyc_a: assert property (off_time_cycles ==
        (regulation_off_time == 2'b00 ? 16'h07d0 : regulation_off_time == 2'b01 ? 16'h0bb8 :
        regulation_off_time == 2'b10 ? 16'h0fa0 : 16'h1388))
        else $error("off time cycles wrong");
    ola_lows_a: assert property (bridge_mode == HBC_MODE_INDEP &&
        load_type_sel == HBC_LOAD_LOWSIDE |-> !openload_active_en)
        else $error("open-load on for low-side load");
    cfg_hold_a: assert property (cfg_wr |=> $stable(overcurrent_retry))
        else $error("locked config written");
    pin_lock_a: assert property ($stable(enable_input1_pin) [*3] ##0 !unl_q
        |-> enable_input1 == enable_input1_pin) else $error("locked input not pin");
endmodule : hbc_regs_chk
bind hbc_regs hbc_regs_chk chk_u (.*);

/* testbench/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the register block
module tb import hbc_pkg::*;;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_en, fault_detected = 1'b0;
    logic shutoff_pin = 1'b0, enable_input1_pin = 1'b0, phase_input2_pin = 1'b0;
    logic [7:0] addr, wdata, rdata, rv;
    logic fault_clear_pulse, fault_indicator_pin_n, shutoff_1, shutoff_2, enable_input1;
    logic phase_input2, openload_active_en, overvoltage_check_en, spread_clock_en;
    logic overcurrent_retry, overtemp_retry, overvoltage_retry, undervoltage_retry;
    logic openload_retry, pwm_extend;
    logic [1:0] overvoltage_threshold_sel, load_type_sel, regulation_off_time, bridge_mode;
    logic [2:0] current_trip_level, slew_rate_sel;
    logic [15:0] off_time_cycles;
    int miscompares = 0, compares = 0, cyc = 0;
    hbc_regs dut_u (.*);
    hbc_host host_u (.*);
    always #5 ref_clk = ~ref_clk;
    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        chk(rv, e);
    endtask : rchk
    task automatic t_reset();
        rchk(HBC_OFS_CMD, 8'h09);
        rchk(HBC_OFS_PIN, 8'h0c);
        rchk(HBC_OFS_PROT, 8'h10);
        rchk(HBC_OFS_DRV, 8'h00);
        rchk(HBC_OFS_TMD, 8'h40);
        rchk(HBC_OFS_COMB, 8'h04);
        rchk(8'h00, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pins();
        @(posedge ref_clk);
        enable_input1_pin <= 1'b1;
        phase_input2_pin <= 1'b1;
        host_u.wr(HBC_OFS_PIN, 8'h00);
        chk(enable_input1, 1'b1);
        rchk(HBC_OFS_PIN, 8'h0c);
        host_u.wr(HBC_OFS_CMD, 8'h11);
        host_u.wr(HBC_OFS_PIN, 8'hff);
        rchk(HBC_OFS_PIN, 8'h0f);
        @(posedge ref_clk);
        enable_input1_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk({enable_input1, shutoff_1}, 2'b10);
        host_u.wr(HBC_OFS_COMB, 8'h01);
        chk({shutoff_1, phase_input2}, 2'b11);
        host_u.wr(HBC_OFS_PIN, 8'h00);
        chk({enable_input1, phase_input2}, 2'b00);
        host_u.wr(HBC_OFS_TMD, 8'h02);
        host_u.wr(HBC_OFS_PIN, 8'h04);
        chk({shutoff_1, shutoff_2}, 2'h1);
        host_u.wr(HBC_OFS_TMD, 8'h40);
        chk({shutoff_1, shutoff_2}, 2'h0);
        host_u.wr(HBC_OFS_CMD, 8'h19);
        host_u.wr(HBC_OFS_PIN, 8'hff);
        rchk(HBC_OFS_PIN, 8'h04);
        $display("test pins done");
    endtask : t_pins
    task automatic t_cfg();
        host_u.wr(HBC_OFS_CMD, 8'h02);
        host_u.wr(HBC_OFS_PROT, 8'hff);
        rchk(HBC_OFS_PROT, 8'h10);
        host_u.wr(HBC_OFS_CMD, 8'h00);
        host_u.wr(HBC_OFS_PROT, 8'he5);
        chk({openload_active_en, spread_clock_en}, 2'h3);
        chk(overvoltage_threshold_sel, 2'h3);
        chk({overcurrent_retry, overtemp_retry, overvoltage_retry}, 3'h2);
        chk({undervoltage_retry, openload_retry}, 2'h1);
        chk(overvoltage_check_en, 1'b0);
        host_u.wr(HBC_OFS_DRV, 8'hff);
        rchk(HBC_OFS_DRV, 8'he7);
        chk({pwm_extend, load_type_sel, current_trip_level}, 6'h3f);
        host_u.wr(HBC_OFS_TMD, 8'hff);
        rchk(HBC_OFS_TMD, 8'hdf);
        chk({slew_rate_sel, bridge_mode}, 5'h1f);
        for (int k = 0; k < 4; k++) begin
            host_u.wr(HBC_OFS_TMD, 8'(k << 6));
            chk(off_time_cycles, 16'(2000 + 1000 * k));
            chk(regulation_off_time, 16'(k));
        end
        host_u.wr(HBC_OFS_TMD, 8'h02);
        host_u.wr(HBC_OFS_DRV, 8'h20);
        chk(openload_active_en, 1'b0);
        host_u.wr(HBC_OFS_DRV, 8'h00);
        chk(openload_active_en, 1'b1);
        $display("test config done");
    endtask : t_cfg
    task automatic t_clear();
        @(posedge ref_clk);
        fault_detected <= 1'b1;
        repeat (2) @(posedge ref_clk);
        fault_detected <= 1'b0;
        host_u.wr(HBC_OFS_CMD, 8'h80);
        chk({fault_clear_pulse, fault_indicator_pin_n}, 2'h2);
        rchk(HBC_OFS_CMD, 8'h00);
        chk(fault_indicator_pin_n, 1'b1);
        $display("test clear done");
    endtask : t_clear
    task automatic tally_and_finish();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Reset for 12 cycles, then each test
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_pins();
        t_cfg();
        t_clear();
        // Second reset in mid-run; every register must return to its reset value
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        tally_and_finish();
    end
endmodule : tb
